// file: logic/ccd_pkg.sv
// Package of the chop and current-detect configuration block.
// Holds register indices, field positions, reset values and decode helpers.
// Assumes a 16-bit register word carried in the low half of a 32-bit bus.
package ccd_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0] IDX_SPARE     = 6'h05;
  localparam logic [5:0] IDX_CONFIG    = 6'h06;
  localparam logic [5:0] IDX_LIM_HIGH  = 6'h07;
  localparam logic [5:0] IDX_LIM_LOW   = 6'h08;
  localparam logic [5:0] IDX_OVERSAMP  = 6'h10;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h11;
  localparam logic [5:0] IDX_IRQ_MASK  = 6'h12;
  localparam logic [5:0] IDX_STATE     = 6'h13;

  // ****************************************************************
  // Reset values and field layouts
  // ****************************************************************
  localparam logic [15:0] RST_SPARE    = 16'h0000;
  localparam logic [15:0] RST_CONFIG   = 16'h0600;
  localparam logic [15:0] RST_LIM_HIGH = 16'h0000;
  localparam logic [15:0] RST_LIM_LOW  = 16'h0000;
  localparam logic [2:0]  RST_OVERSAMP = 3'h3;
  localparam logic [15:0] LIM_LOW_MASK = 16'hFF0F;
  localparam int          IRQ_W        = 3;
  localparam int          EV_DETECT    = 0;
  localparam int          EV_SPAN_END  = 1;
  localparam int          EV_SETTLED   = 2;
  localparam int          SAMPLE_W     = 24;

  typedef struct packed {
    logic [2:0] spare_bits;
    logic [3:0] chop_settle_delay;
    logic       chop_on;
    logic       detect_every_channel;
    logic [2:0] detect_exceed_count;
    logic [2:0] detect_span;
    logic       detect_mode_on;
  } ccd_config_t;

  // Byte-lane merge of a 16-bit register under the Wishbone selects
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] dat,
                                             input logic [1:0] sel);
    lane_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Measurement span in conversion periods
  function automatic logic [11:0] span_periods(input logic [2:0] code);
    unique case (code)
      3'h0: span_periods = 12'h080;
      3'h1: span_periods = 12'h100;
      3'h2: span_periods = 12'h200;
      3'h3: span_periods = 12'h300;
      3'h4: span_periods = 12'h500;
      3'h5: span_periods = 12'h700;
      3'h6: span_periods = 12'hA00;
      3'h7: span_periods = 12'hE00;
    endcase
  endfunction

  // Modulator periods per conversion period, 128 up to 16384
  function automatic logic [14:0] oversamp_ratio(input logic [2:0] code);
    oversamp_ratio = 15'h0080 << code;
  endfunction

endpackage

// file: logic/ccd_settle.sv
// Settling delay counter for global-chop operation.
// Assumes tick_i is a one-cycle modulator clock strobe on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ccd_settle (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // Control
  input  wire logic       start_i,
  input  wire logic       tick_i,
  input  wire logic [3:0] code_i,
  // Status
  output logic            busy_o,
  output logic            done_o
);

  logic [16:0] cnt_q;
  logic        busy_q;
  logic        done_q;
  logic [16:0] target;
  logic        last;

  // Delay is two to the power of code plus one
  assign target = 17'h00001 << (5'(code_i) + 5'h01);
  assign last   = busy_q && tick_i && (cnt_q == target - 17'h00001);

  // Count modulator periods until the delay has passed
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q  <= 17'h00000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= last;
      if (start_i) begin
        cnt_q  <= 17'h00000;
        busy_q <= 1'b1;
      end else if (last) begin
        busy_q <= 1'b0;
      end else if (busy_q && tick_i) begin
        cnt_q <= cnt_q + 17'h00001;
      end
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;

endmodule
`default_nettype wire

// file: logic/ccd_detect.sv
// Current-detect engine: counts threshold exceedances within a span.
// Assumes samples and conversion strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ccd_detect #(
  parameter int NCH = 3
) (
  // Clock and reset
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 reset_i,
  // Configuration
  input  wire logic                                 enable_i,
  input  wire logic                                 gate_i,
  input  wire logic                                 every_i,
  input  wire logic [2:0]                           count_code_i,
  input  wire logic [2:0]                           span_code_i,
  input  wire logic [ccd_pkg::SAMPLE_W-1:0]         limit_i,
  // Data
  input  wire logic                                 conv_tick_i,
  input  wire logic                                 samp_valid_i,
  input  wire logic [NCH-1:0][ccd_pkg::SAMPLE_W-1:0] samp_data_i,
  // Events
  output logic                                      detect_o,
  output logic                                      span_end_o
);

  logic [NCH-1:0] over;
  logic [11:0]    span_q;
  logic [7:0]     hits_q;
  logic           fired_q;
  logic           detect_q;
  logic           span_end_q;
  logic           hit;
  logic           last;
  logic [7:0]     need;

  // Magnitude of each result against the 24-bit limit
  for (genvar c = 0; c < NCH; c++) begin : g_cmp
    logic [ccd_pkg::SAMPLE_W-1:0] mag;
    assign mag     = samp_data_i[c][ccd_pkg::SAMPLE_W-1] ? -samp_data_i[c] : samp_data_i[c];
    assign over[c] = mag > limit_i;
  end

  assign hit  = samp_valid_i && gate_i && (every_i ? &over : |over);
  assign need = 8'h01 << count_code_i;
  assign last = conv_tick_i && (span_q == ccd_pkg::span_periods(span_code_i) - 12'h001);

  // Span counter and exceedance counter, cleared at each span end
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      span_q     <= 12'h000;
      hits_q     <= 8'h00;
      fired_q    <= 1'b0;
      detect_q   <= 1'b0;
      span_end_q <= 1'b0;
    end else if (!enable_i) begin
      span_q     <= 12'h000;
      hits_q     <= 8'h00;
      fired_q    <= 1'b0;
      detect_q   <= 1'b0;
      span_end_q <= 1'b0;
    end else begin
      span_end_q <= last;
      detect_q   <= hit && !fired_q && (hits_q + 8'h01 == need);
      if (last) begin
        span_q  <= 12'h000;
        hits_q  <= 8'h00;
        fired_q <= 1'b0;
      end else begin
        if (conv_tick_i) begin
          span_q <= span_q + 12'h001;
        end
        if (hit && !fired_q) begin
          hits_q  <= hits_q + 8'h01;
          fired_q <= (hits_q + 8'h01 == need);
        end
      end
    end
  end

  assign detect_o   = detect_q;
  assign span_end_o = span_end_q;

endmodule
`default_nettype wire

// file: logic/ccd_top.sv
// Chop and current-detect configuration block with a Wishbone slave.
// Assumes a classic Wishbone master and modulator, chop and sample strobes
// from logic on the same clock.
// Counts assume mod_tick_i pulses once per modulator clock period.
//
// Behaviour
// - Chop settling waits two to code-plus-one periods
// - Config word resets to 0600h, chop off
// - Bit 7 selects any or every channel
// - Exceed count field selects 1 to 128
// - Span field selects 128 to 3584 periods
// - Upper limit word is read-write, resets zero
// - Low limit register holds bits 15:8 and 3:0
// - Conversion period follows oversampling ratio code
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ccd_top #(
  parameter int NCH = 3
) (
  // Clock and reset
  input  wire logic                                  sys_clk_i,
  input  wire logic                                  reset_i,
  // Wishbone slave
  input  wire logic                                  wb_cyc_i,
  input  wire logic                                  wb_stb_i,
  input  wire logic                                  wb_we_i,
  input  wire logic [7:0]                            wb_adr_i,
  input  wire logic [3:0]                            wb_sel_i,
  input  wire logic [31:0]                           wb_dat_i,
  output logic      [31:0]                           wb_dat_o,
  output logic                                       wb_ack_o,
  // Converter side
  input  wire logic                                  mod_tick_i,
  input  wire logic                                  chop_swap_i,
  input  wire logic                                  samp_valid_i,
  input  wire logic [NCH-1:0][ccd_pkg::SAMPLE_W-1:0] samp_data_i,
  // Results
  output logic                                       irq_o,
  output logic                                       detect_o,
  output logic                                       chop_on_o,
  output logic                                       measuring_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Software-visible registers
  logic [15:0]              spare_q;
  ccd_pkg::ccd_config_t     cfg_q;
  logic [15:0]              lim_hi_q;
  logic [15:0]              lim_lo_q;
  logic [2:0]               osr_q;

  // Interrupt status, mask and next status
  logic [ccd_pkg::IRQ_W-1:0] sts_q;
  logic [ccd_pkg::IRQ_W-1:0] msk_q;
  logic [ccd_pkg::IRQ_W-1:0] sts_d;

  // Bus answer
  logic                     ack_q;
  logic [31:0]              rdat_q;

  // Output flops and chop edge memory
  logic                     irq_q;
  logic                     detect_q;
  logic                     meas_q;
  logic                     chop_on_q;
  logic                     chop_prev_q;

  // Conversion period divider
  logic [14:0]              conv_cnt_q;
  logic                     conv_tick_q;

  // Bus decode
  logic                     req;
  logic                     wr;
  logic [5:0]               idx;
  logic                     sel_spare;
  logic                     sel_cfg;
  logic                     sel_lim_hi;
  logic                     sel_lim_lo;
  logic                     sel_osr;
  logic                     sel_sts;
  logic                     sel_msk;
  logic                     sel_state;

  // Write data path and read selection
  logic [15:0]              wdat;
  logic [1:0]               wsel;
  logic [15:0]              rmux;

  // Interrupt terms
  logic [ccd_pkg::IRQ_W-1:0] w1c;
  logic [ccd_pkg::IRQ_W-1:0] events;

  // Measurement control and sub-block results
  logic [ccd_pkg::SAMPLE_W-1:0] limit;
  logic                     settle_start;
  logic                     settle_busy;
  logic                     settle_done;
  logic                     gate;
  logic                     ev_detect;
  logic                     ev_span_end;
  logic                     conv_last;

  // ****************************************************************
  // Wishbone decode
  // ****************************************************************

  // Request seen once per access, ack follows in the next cycle
  assign req        = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr         = req && wb_we_i;
  assign idx        = wb_adr_i[7:2];
  assign wdat       = wb_dat_i[15:0];
  assign wsel       = wb_sel_i[1:0];
  assign sel_spare  = idx == ccd_pkg::IDX_SPARE;
  assign sel_cfg    = idx == ccd_pkg::IDX_CONFIG;
  assign sel_lim_hi = idx == ccd_pkg::IDX_LIM_HIGH;
  assign sel_lim_lo = idx == ccd_pkg::IDX_LIM_LOW;
  assign sel_osr    = idx == ccd_pkg::IDX_OVERSAMP;
  assign sel_sts    = idx == ccd_pkg::IDX_IRQ_STAT;
  assign sel_msk    = idx == ccd_pkg::IDX_IRQ_MASK;
  assign sel_state  = idx == ccd_pkg::IDX_STATE;

  // Read selection, unmapped indices read as zero
  assign rmux = sel_spare  ? spare_q :
                sel_cfg    ? cfg_q :
                sel_lim_hi ? lim_hi_q :
                sel_lim_lo ? (lim_lo_q & ccd_pkg::LIM_LOW_MASK) :
                sel_osr    ? {13'h0000, osr_q} :
                sel_sts    ? {13'h0000, sts_q} :
                sel_msk    ? {13'h0000, msk_q} :
                sel_state  ? {14'h0000, meas_q, settle_busy} :
                16'h0000;

  // Bus answer flops
  // Read data is zero whenever ack is low
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? {16'h0000, rmux} : 32'h00000000;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************

  // Spare word and config store what is written; zeros are the host's duty
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      spare_q <= ccd_pkg::RST_SPARE;
      cfg_q   <= ccd_pkg::RST_CONFIG;
    end else begin
      if (wr && sel_spare) begin
        spare_q <= ccd_pkg::lane_merge(spare_q, wdat, wsel);
      end
      if (wr && sel_cfg) begin
        cfg_q <= ccd_pkg::lane_merge(cfg_q, wdat, wsel);
      end
    end
  end

  // Limit words and oversampling code
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lim_hi_q <= ccd_pkg::RST_LIM_HIGH;
      lim_lo_q <= ccd_pkg::RST_LIM_LOW;
      osr_q    <= ccd_pkg::RST_OVERSAMP;
    end else begin
      if (wr && sel_lim_hi) begin
        lim_hi_q <= ccd_pkg::lane_merge(lim_hi_q, wdat, wsel);
      end
      if (wr && sel_lim_lo) begin
        lim_lo_q <= ccd_pkg::lane_merge(lim_lo_q, wdat, wsel) & ccd_pkg::LIM_LOW_MASK;
      end
      if (wr && sel_osr && wsel[0]) begin
        osr_q <= wdat[2:0];
      end
    end
  end

  // Full 24-bit limit from upper word and lower byte
  // Hits are strictly above it, so an equal result is no hit
  assign limit = {lim_hi_q, lim_lo_q[15:8]};

  // ****************************************************************
  // Conversion period and chop settling
  // ****************************************************************

  // One conversion period every ratio modulator periods
  // Lowering the ratio mid-period lets the count wrap once
  assign conv_last = mod_tick_i && (conv_cnt_q == ccd_pkg::oversamp_ratio(osr_q) - 15'h0001);

  // Divider of modulator ticks into conversion ticks
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_cnt_q  <= 15'h0000;
      conv_tick_q <= 1'b0;
    end else begin
      conv_tick_q <= conv_last;
      if (conv_last) begin
        conv_cnt_q <= 15'h0000;
      end else if (mod_tick_i) begin
        conv_cnt_q <= conv_cnt_q + 15'h0001;
      end
    end
  end

  // Settling restarts when chop turns on or the chop phase swaps
  // A swap during settling starts the full delay again
  assign settle_start = cfg_q.chop_on && (!chop_prev_q || chop_swap_i);

  // Samples are refused from the start cycle until settling ends
  assign gate         = !cfg_q.chop_on || (!settle_busy && !settle_start);

  ccd_settle u_settle (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .start_i   (settle_start),
    .tick_i    (mod_tick_i),
    .code_i    (cfg_q.chop_settle_delay),
    .busy_o    (settle_busy),
    .done_o    (settle_done)
  );

  // ****************************************************************
  // Current detection
  // ****************************************************************

  // Exceedance counting over one measurement span
  ccd_detect #(
    .NCH (NCH)
  ) u_detect (
    .sys_clk_i    (sys_clk_i),
    .reset_i      (reset_i),
    .enable_i     (cfg_q.detect_mode_on),
    .gate_i       (gate),
    .every_i      (cfg_q.detect_every_channel),
    .count_code_i (cfg_q.detect_exceed_count),
    .span_code_i  (cfg_q.detect_span),
    .limit_i      (limit),
    .conv_tick_i  (conv_tick_q),
    .samp_valid_i (samp_valid_i),
    .samp_data_i  (samp_data_i),
    .detect_o     (ev_detect),
    .span_end_o   (ev_span_end)
  );

  // ****************************************************************
  // Interrupts
  // ****************************************************************

  // Sticky status, write one to clear, a new event wins over the clear
  assign events = {settle_done, ev_span_end, ev_detect};
  assign w1c    = (wr && sel_sts && wsel[0]) ? wdat[ccd_pkg::IRQ_W-1:0] : '0;
  assign sts_d  = (sts_q & ~w1c) | events;

  // Status and mask flops; irq follows the next status
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sts_q <= '0;
      msk_q <= '0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & msk_q);
      if (wr && sel_msk && wsel[0]) begin
        msk_q <= wdat[ccd_pkg::IRQ_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Result outputs
  // ****************************************************************

  // Registered copies of the detect event, chop bit and measuring state
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      detect_q    <= 1'b0;
      meas_q      <= 1'b0;
      chop_on_q   <= 1'b0;
      chop_prev_q <= 1'b0;
    end else begin
      detect_q    <= ev_detect;
      meas_q      <= cfg_q.detect_mode_on && gate;
      chop_on_q   <= cfg_q.chop_on;
      chop_prev_q <= cfg_q.chop_on;
    end
  end

  // Ports come straight from the flops
  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = rdat_q;
  assign irq_o       = irq_q;
  assign detect_o    = detect_q;
  assign chop_on_o   = chop_on_q;
  assign measuring_o = meas_q;

endmodule
`default_nettype wire

// file: testbench/ccd_top_chk.sv
// Port checker of the chop and current-detect block.
// Assumes it is bound onto ccd_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ccd_top_chk (
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Converter side and results
  input wire logic        samp_valid_i,
  input wire logic        detect_o,
  input wire logic        chop_on_o
);
  // ****************************************************************
  // Request decode and properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Taken request, config write of the high lane, chop bit
  wire take_w   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire cfg_wr_w = take_w && wb_we_i && wb_adr_i[7:2] == ccd_pkg::IDX_CONFIG && wb_sel_i[1];
  wire dat8_w   = wb_dat_i[8];

  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_take: assert property (take_w |=> wb_ack_o)
    else $error("taken request not acknowledged next cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero while idle");
  a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_chop_follows_cfg: assert property (cfg_wr_w |-> ##2 chop_on_o == $past(dat8_w, 2))
    else $error("chop output does not follow config bit 8");
  a_chop_needs_write: assert property ((!cfg_wr_w)[*3] |-> $stable(chop_on_o))
    else $error("chop output changed without config write");
  a_detect_after_sample: assert property ($rose(detect_o) |-> $past(samp_valid_i, 2) ##1 !detect_o)
    else $error("detect pulse not two cycles after a sample");
endmodule
`default_nettype wire

// file: testbench/ccd_conv_model.sv
// Converter-side model: modulator ticks and sample strobes.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module ccd_conv_model (
  // Clock
  input  wire logic                              sys_clk_i,
  // Converter strobes
  output logic                                   mod_tick_o,
  output logic                                   samp_valid_o,
  output logic [2:0][ccd_pkg::SAMPLE_W-1:0]      samp_data_o
);
  // Quiet start
  initial begin
    mod_tick_o   = 1'b0;
    samp_valid_o = 1'b0;
    samp_data_o  = '0;
  end
  // Run n consecutive modulator ticks
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk_i);
      mod_tick_o <= 1'b1;
    end
    @(posedge sys_clk_i);
    mod_tick_o <= 1'b0;
  endtask
  // One result per channel; data inverted once no longer valid
  task automatic sample(input logic [2:0][ccd_pkg::SAMPLE_W-1:0] d);
    @(posedge sys_clk_i);
    samp_valid_o <= 1'b1;
    samp_data_o  <= d;
    @(posedge sys_clk_i);
    samp_valid_o <= 1'b0;
    samp_data_o  <= ~d;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_ccd_top.sv
// Self-checking bench of the chop and current-detect block.
// Assumes the converter model and the port checker beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_top;
  typedef struct packed {
    logic [7:0]  adr;
    logic [1:0]  sel;
    logic [15:0] dat;
    logic [15:0] exp;
  } ccd_row_t;
  // Design signals
  logic        sys_clk_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        wb_cyc_i  = 1'b0;
  logic        wb_stb_i  = 1'b0;
  logic        wb_we_i   = 1'b0;
  logic [7:0]  wb_adr_i  = 8'h00;
  logic [3:0]  wb_sel_i  = 4'h0;
  logic [31:0] wb_dat_i  = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, tick, valid, irq_o, detect_o, chop_on_o, measuring_o;
  logic [2:0][ccd_pkg::SAMPLE_W-1:0] data;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  logic [15:0] q;
  logic [3:0]  lane = 4'h3;
  logic        swap = 1'b0;
  // Sel 0 rows are reads only; reset values come first
  ccd_row_t rows [13] = '{
    '{8'h14, 2'h0, 16'h0000, 16'h0000}, '{8'h18, 2'h0, 16'h0000, 16'h0600},
    '{8'h1C, 2'h0, 16'h0000, 16'h0000}, '{8'h20, 2'h0, 16'h0000, 16'h0000},
    '{8'h40, 2'h0, 16'h0000, 16'h0003}, '{8'h14, 2'h3, 16'h0000, 16'h0000},
    '{8'h18, 2'h3, 16'h1E7E, 16'h1E7E}, '{8'h1C, 2'h3, 16'hA5C3, 16'hA5C3},
    '{8'h1C, 2'h1, 16'h1234, 16'hA534}, '{8'h20, 2'h3, 16'h5AFF, 16'h5A0F},
    '{8'h20, 2'h2, 16'h3300, 16'h330F}, '{8'hFC, 2'h3, 16'hFFFF, 16'h0000},
    '{8'h40, 2'h3, 16'h0000, 16'h0000}};

  // Clock
  always #12.5 sys_clk_i = ~sys_clk_i;

  // Design and converter model
  ccd_top #(.NCH(3)) ccd_top_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_tick_i(tick),
    .chop_swap_i(swap), .samp_valid_i(valid), .samp_data_i(data), .irq_o(irq_o),
    .detect_o(detect_o), .chop_on_o(chop_on_o), .measuring_o(measuring_o));
  ccd_conv_model ccd_conv_model_inst (.sys_clk_i(sys_clk_i), .mod_tick_o(tick),
    .samp_valid_o(valid), .samp_data_o(data));

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] dat);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= lane;
    wb_dat_i <= {16'h0000, dat};
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) n_mismatch++;
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    chk16(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  // Watch a few cycles for a detection pulse
  task automatic see_det(input logic e);
    logic s;
    s = 1'b0;
    repeat (6) begin
      @(posedge sys_clk_i);
      if (detect_o === 1'b1) s = 1'b1;
    end
    chk1("detect_o", e, s);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      lane = {2'h0, rows[i].sel};
      if (rows[i].sel != 2'h0) wb(1'b1, rows[i].adr, rows[i].dat);
      wb(1'b0, rows[i].adr, 16'h0000);
      chk16("register", rows[i].exp, q);
    end
    lane = 4'h3;
    // Chop settling with the shortest delay code
    wb(1'b1, 8'h18, 16'h0100);
    wb(1'b0, 8'h4C, 16'h0000);
    chk16("state", 16'h0001, q);
    ccd_conv_model_inst.tick(1);
    wb(1'b0, 8'h4C, 16'h0000);
    chk16("state", 16'h0001, q);
    ccd_conv_model_inst.tick(1);
    wb(1'b0, 8'h44, 16'h0000);
    chk16("status", 16'h0004, q);
    // A chop phase swap restarts settling
    swap <= 1'b1;
    @(posedge sys_clk_i);
    swap <= 1'b0;
    wb(1'b0, 8'h4C, 16'h0000);
    chk16("state", 16'h0001, q);
    ccd_conv_model_inst.tick(2);
    // Any-channel detection at the strict threshold boundary
    wb(1'b1, 8'h18, 16'h0000);
    wb(1'b1, 8'h1C, 16'h0010);
    wb(1'b1, 8'h20, 16'h0000);
    wb(1'b1, 8'h48, 16'h0007);
    wb(1'b1, 8'h44, 16'h0007);
    wb(1'b1, 8'h18, 16'h0001);
    ccd_conv_model_inst.sample({24'h0, 24'h001000, 24'h0});
    see_det(1'b0);
    ccd_conv_model_inst.sample({24'h0, 24'h001001, 24'h0});
    see_det(1'b1);
    chk1("irq_o", 1'b1, irq_o);
    wb(1'b0, 8'h44, 16'h0000);
    chk16("status", 16'h0001, q);
    wb(1'b1, 8'h44, 16'h0001);
    repeat (3) @(posedge sys_clk_i);
    chk1("irq_o", 1'b0, irq_o);
    // Every-channel mode needs all three, negative included
    wb(1'b1, 8'h18, 16'h0000);
    wb(1'b1, 8'h18, 16'h0081);
    ccd_conv_model_inst.sample({24'h0, 24'h001001, 24'h0});
    see_det(1'b0);
    ccd_conv_model_inst.sample({24'h7FFFFF, 24'h001001, 24'hFFEFFF});
    see_det(1'b1);
    // Exceed count code 1 needs two hits
    wb(1'b1, 8'h18, 16'h0000);
    wb(1'b1, 8'h18, 16'h0011);
    ccd_conv_model_inst.sample({24'h0, 24'h0, 24'h002000});
    see_det(1'b0);
    ccd_conv_model_inst.sample({24'h0, 24'h0, 24'h002000});
    see_det(1'b1);
    // Shortest span: 128 conversions of 128 ticks
    wb(1'b1, 8'h18, 16'h0000);
    wb(1'b1, 8'h44, 16'h0007);
    wb(1'b1, 8'h18, 16'h0001);
    ccd_conv_model_inst.tick(16000);
    chk1("measuring_o", 1'b1, measuring_o);
    wb(1'b0, 8'h44, 16'h0000);
    chk16("status", 16'h0000, q);
    ccd_conv_model_inst.tick(600);
    wb(1'b0, 8'h44, 16'h0000);
    chk16("status", 16'h0002, q);
    // Mid-run reset brings back the reset values
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    wb(1'b0, 8'h18, 16'h0000);
    chk16("config", 16'h0600, q);
    wb(1'b0, 8'h40, 16'h0000);
    chk16("oversampling", 16'h0003, q);
    end_of_test();
  end

  // Watchdog
  initial begin
    #1_500_000;
    n_mismatch++;
    end_of_test();
  end
endmodule
bind ccd_top ccd_top_chk ccd_top_chk_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .samp_valid_i(samp_valid_i), .detect_o(detect_o), .chop_on_o(chop_on_o));
`default_nettype wire
